// *** tb/disk_ctrl_cmd_decode_tb_top.sv ***
// bench for the disk command decoder: host model on the command and result channels, bench on the rest
// assumes the decoder and host model compiled before this file
`timescale 1ns/1ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, (e), (a)); end end
module disk_ctrl_cmd_decode_tb_top;
  logic sys_clk, reset_n, clk_en, cmd_valid, cmd_ready, res_valid, res_read, non_dma_flag, format_done, rw_done;
  logic gap_select, write_gate_select, implied_seek_enable, fifo_disable, poll_disable, id_found;
  logic [7:0] cmd_byte, res_byte, present_cylinder_0, present_cylinder_1, present_cylinder_2, present_cylinder_3;
  logic [3:0] step_rate_time, head_unload_time, fifo_threshold;
  logic [6:0] head_load_time;
  logic [7:0] sector_count, final_sector_number, precomp_start_track, id_status_0, id_status_1, id_status_2;
  logic [7:0] id_cylinder, id_head, id_sector, id_size, seek_steps, b;
  logic seek_start, seek_dir, seek_head, read_id_start, read_id_head, double_density_select, standby_enter, foreign_cmd;
  logic config_lock;
  logic [1:0] seek_drive, read_id_drive;
  int fails, check_count, cycles;
  disk_ctrl_cmd_decode i_disk_ctrl_cmd_decode (.*);
  disk_host_model i_disk_host_model (.*);
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic check_dump(input logic lk, input logic [3:0] sel, input logic [7:0] mid);
    logic [7:0] ex [10];
    ex = '{present_cylinder_0, present_cylinder_1, present_cylinder_2, present_cylinder_3,
      {step_rate_time, head_unload_time}, {head_load_time, non_dma_flag}, mid,
      {lk, 1'b0, sel, gap_select, write_gate_select},
      {1'b0, implied_seek_enable, fifo_disable, poll_disable, fifo_threshold}, precomp_start_track};
    i_disk_host_model.send(8'h0e);
    for (int i = 0; i < 10; i++) begin
      i_disk_host_model.pop(i % 3, b);
      `CHK("dump byte", ex[i], b)
    end
    `CHK("dump length", 1'b0, res_valid)
  endtask : check_dump
  task automatic test_seek();
    i_disk_host_model.send(8'hcf);
    i_disk_host_model.send(8'h05);
    i_disk_host_model.send(8'h0a);
    `CHK("seek start", 1'b1, seek_start)
    `CHK("seek fields", 12'hb0a, {seek_dir, seek_drive, seek_head, seek_steps})
    i_disk_host_model.send(8'h8f);
    i_disk_host_model.send(8'h03);
    i_disk_host_model.send(8'hff);
    clk_en = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    clk_en = 1'b1;
    `CHK("frozen seek start", 1'b1, seek_start)
    `CHK("seek fields", 12'h6ff, {seek_dir, seek_drive, seek_head, seek_steps})
    `CHK("seek no result", 1'b0, res_valid)
    $display("test seek done");
  endtask : test_seek
  task automatic test_lock();
    i_disk_host_model.send(8'h94);
    `CHK("lock set", 1'b1, config_lock)
    i_disk_host_model.pop(0, b);
    `CHK("lock result", 8'h10, b)
    check_dump(1'b1, 4'h8, final_sector_number);
    i_disk_host_model.send(8'h14);
    `CHK("lock clear", 1'b0, config_lock)
    i_disk_host_model.pop(2, b);
    `CHK("lock result", 8'h00, b)
    $display("test lock done");
  endtask : test_lock
  task automatic pulse_done(input logic fmt);
    @(posedge sys_clk);
    #1;
    if (fmt) format_done = 1'b1;
    else rw_done = 1'b1;
    @(posedge sys_clk);
    #1;
    format_done = 1'b0;
    rw_done = 1'b0;
  endtask : pulse_done
  task automatic test_last_cmd();
    pulse_done(1'b1);
    check_dump(1'b0, 4'h8, sector_count);
    // fresh field values so every dumped input but sector_count is seen to move
    {present_cylinder_0, present_cylinder_1, present_cylinder_2, present_cylinder_3} = 32'ha5b6c7d8;
    {step_rate_time, head_unload_time, head_load_time, non_dma_flag} = 16'hc386;
    {sector_count, final_sector_number, precomp_start_track} = 24'h3c4d1e;
    {gap_select, write_gate_select, implied_seek_enable, fifo_disable, poll_disable} = 5'h0a;
    fifo_threshold = 4'h9;
    pulse_done(1'b0);
    check_dump(1'b0, 4'h8, final_sector_number);
    $display("test last command done");
  endtask : test_last_cmd
  task automatic test_read_id();
    logic [7:0] ex [7];
    i_disk_host_model.send(8'h4a);
    i_disk_host_model.send(8'h06);
    `CHK("read id start", 1'b1, read_id_start)
    `CHK("read id fields", 4'hb, {read_id_drive, read_id_head, double_density_select})
    `CHK("seek drive kept", 2'h3, seek_drive)
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("wait refuses", 2'h0, {cmd_ready, res_valid})
    ex = '{8'h40, 8'h00, 8'h00, 8'h07, 8'h01, 8'h09, 8'h02};
    {id_status_0, id_status_1, id_status_2, id_cylinder, id_head, id_sector, id_size} = 56'h40000007010902;
    id_found = 1'b1;
    @(posedge sys_clk);
    #1;
    id_found = 1'b0;
    {id_status_0, id_status_1, id_status_2, id_cylinder, id_head, id_sector, id_size} = 56'hffffffffffffff;
    for (int i = 0; i < 7; i++) begin
      i_disk_host_model.pop(i % 2, b);
      `CHK("read id byte", ex[i], b)
    end
    check_dump(1'b0, 4'h4, final_sector_number);
    $display("test read id done");
  endtask : test_read_id
  task automatic test_invalid();
    logic [7:0] codes [6];
    codes = '{8'h00, 8'h01, 8'h0b, 8'h17, 8'h18, 8'h1f};
    foreach (codes[i]) begin
      i_disk_host_model.send(codes[i]);
      `CHK("standby", 1'b1, standby_enter)
      i_disk_host_model.pop(0, b);
      `CHK("invalid status", 8'h80, b)
      `CHK("single byte", 1'b0, res_valid)
    end
    i_disk_host_model.send(8'h03);
    `CHK("foreign", 2'h2, {foreign_cmd, res_valid})
    $display("test invalid done");
  endtask : test_invalid
  initial begin
    {reset_n, clk_en, format_done, rw_done, id_found} = 5'h08;
    {present_cylinder_0, present_cylinder_1, present_cylinder_2, present_cylinder_3} = 32'h11223344;
    {step_rate_time, head_unload_time, head_load_time, non_dma_flag} = 16'h5a79;
    {sector_count, final_sector_number, precomp_start_track} = 24'h122480;
    {gap_select, write_gate_select, implied_seek_enable, fifo_disable, poll_disable} = 5'h15;
    fifo_threshold = 4'h6;
    {id_status_0, id_status_1, id_status_2, id_cylinder, id_head, id_sector, id_size} = 56'h0;
    repeat (16) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    `CHK("reset state", 3'h4, {cmd_ready, res_valid, config_lock})
    test_seek();
    test_lock();
    test_last_cmd();
    test_read_id();
    test_invalid();
    complete_run();
  end
endmodule : disk_ctrl_cmd_decode_tb_top

// *** tb/disk_host_model.sv ***
// host side model: writes command bytes and pops result bytes, promptly or slowly
// assumes the decoder's registered ready and valid outputs on sys_clk
`timescale 1ns/1ps
module disk_host_model (
  input wire logic sys_clk, // controller clock
  output logic cmd_valid, // command byte offered
  output logic [7:0] cmd_byte, // command byte
  input wire logic cmd_ready, // decoder takes a byte
  input wire logic res_valid, // result byte present
  input wire logic [7:0] res_byte, // current result byte
  output logic res_read // pop request
);
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    res_read = 1'b0;
  end
  // send offers one command byte, holds it until the decoder takes it, then withdraws it
  task automatic send(input logic [7:0] cb);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_byte = cb;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_byte = ~cb;
  endtask : send
  task automatic pop(input int slow, output logic [7:0] rb);
    int n;
    n = 0;
    repeat (slow) @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    while (res_valid !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    rb = res_byte;
    res_read = 1'b1;
    @(posedge sys_clk);
    #1;
    res_read = 1'b0;
  endtask : pop
endmodule : disk_host_model

// *** verilog/disk_cmd_pkg.sv ***
// types shared by the disk command decoder
// assumes no surroundings beyond the compiler
package disk_cmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEEK_DRV,
    ST_SEEK_CNT,
    ST_RID_DRV,
    ST_RID_WAIT,
    ST_RESULT
  } state_type;
endpackage : disk_cmd_pkg

// *** verilog/disk_cmd_regs.svh ***
// command codes, field positions and result constants of the disk command decoder
// assumes inclusion by bare name from design files
`ifndef DISK_CMD_REGS_SVH
`define DISK_CMD_REGS_SVH
`define RSEEK_MASK 8'hbf
`define RSEEK_CODE 8'h8f
`define RID_MASK 8'hbf
`define RID_CODE 8'h0a
`define DUMP_CODE 8'h0e
`define LOCK_MASK 8'h7f
`define LOCK_CODE 8'h14
`define DIR_BIT 6
`define DENSITY_BIT 6
`define LOCK_BIT 7
`define HEAD_BIT 2
`define INVALID_STATUS 8'h80
// low five bits of the codes served by other units of the controller
`define FOREIGN_CODES_A 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0c
`define FOREIGN_CODES_B 5'h0d, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h16, 5'h19, 5'h1d
`define LOCK_RES_LEN 4'h1
`define INVALID_RES_LEN 4'h1
`define RID_RES_LEN 4'h7
`define DUMP_RES_LEN 4'ha
`define RES_DEPTH 10
`define LOCK_RESET 1'b0
`define DSEL_RESET 4'h0
`endif

// *** verilog/disk_ctrl_cmd_decode.sv ***
// command decoder for relative seek, register dump, read id, lock and invalid codes
// assumes a byte-wide command/result channel and same-clock controller neighbours
//
// Function
// RULE1 - byte 1x001111 is relative seek, bit 6 direction, then drive and step bytes
// RULE2 - dump byte eight: lock, zero, internal selects, gap and write gate bits
// RULE3 - dump returns sector count when the last command was a format
// RULE4 - dump returns final sector number when last command was read or write
// RULE5 - internal select bits stay inside, never driven to drive select pins
// RULE6 - host keeps internal selects consistent with its digital output register
// RULE7 - read id captures first good id, returns status then cylinder head sector size
// RULE8 - undefined code: no operation, standby, single result byte 80h
// RULE9 - low seven bits 0010100 is lock, bit 7 is stored lock value
// RULE10 - lock result is stored lock in bit 4, zeros elsewhere
// RULE11 - dump returns ten bytes: four cylinders, timings, count, select, configure, precomp
`timescale 1ns/1ps
`include "disk_cmd_regs.svh"
module disk_ctrl_cmd_decode (
  input wire logic sys_clk, // controller clock
  input wire logic reset_n, // synchronous reset
  input wire logic clk_en, // freezes all state when low
  input wire logic cmd_valid, // command byte offered
  input wire logic [7:0] cmd_byte, // command byte
  output logic cmd_ready, // decoder takes a command byte
  output logic res_valid, // result byte present
  output logic [7:0] res_byte, // current result byte
  input wire logic res_read, // host pops the result byte
  input wire logic [7:0] present_cylinder_0, // drive 0 cylinder
  input wire logic [7:0] present_cylinder_1, // drive 1 cylinder
  input wire logic [7:0] present_cylinder_2, // drive 2 cylinder
  input wire logic [7:0] present_cylinder_3, // drive 3 cylinder
  input wire logic [3:0] step_rate_time, // specify field
  input wire logic [3:0] head_unload_time, // specify field
  input wire logic [6:0] head_load_time, // specify field
  input wire logic non_dma_flag, // specify field
  input wire logic [7:0] sector_count, // last format sector count
  input wire logic [7:0] final_sector_number, // last read/write final sector
  input wire logic format_done, // a format command was run
  input wire logic rw_done, // a read or write data command was run
  input wire logic gap_select, // gap select bit
  input wire logic write_gate_select, // write gate select bit
  input wire logic implied_seek_enable, // configure field
  input wire logic fifo_disable, // configure field
  input wire logic poll_disable, // configure field
  input wire logic [3:0] fifo_threshold, // configure field
  input wire logic [7:0] precomp_start_track, // configure field
  input wire logic id_found, // first correct id read
  input wire logic [7:0] id_status_0, // primary status after read id
  input wire logic [7:0] id_status_1, // second status byte
  input wire logic [7:0] id_status_2, // third status byte
  input wire logic [7:0] id_cylinder, // id cylinder
  input wire logic [7:0] id_head, // id head
  input wire logic [7:0] id_sector, // id sector
  input wire logic [7:0] id_size, // id size code
  output logic seek_start, // relative seek request pulse
  output logic seek_dir, // step direction
  output logic [1:0] seek_drive, // drive for seek
  output logic seek_head, // head select for seek
  output logic [7:0] seek_steps, // step count
  output logic read_id_start, // read id request pulse
  output logic [1:0] read_id_drive, // drive for read id
  output logic read_id_head, // head for read id
  output logic double_density_select, // read id density mode
  output logic standby_enter, // invalid code pulse
  output logic foreign_cmd, // code handled by other units
  output logic config_lock // stored lock bit
);
  import disk_cmd_pkg::*;
  function automatic logic is_foreign(input logic [7:0] b);
    case (b[4:0])
      `FOREIGN_CODES_A, `FOREIGN_CODES_B: is_foreign = 1'b1;
      default: is_foreign = 1'b0;
    endcase
  endfunction : is_foreign
  state_type state, next_state;
  logic [7:0] res_buf [`RES_DEPTH];
  logic [7:0] next_buf [`RES_DEPTH];
  logic [3:0] res_count, next_res_count, res_idx, next_res_idx;
  logic [3:0] dsel, next_dsel;
  logic last_fmt, next_last_fmt;
  logic rs_dir, next_rs_dir;
  logic next_res_valid, next_cmd_ready, next_lock;
  logic [7:0] next_res_byte, next_seek_steps;
  logic next_seek_start, next_seek_dir, next_seek_head, next_read_id_start;
  logic [1:0] next_seek_drive, next_read_id_drive;
  logic next_read_id_head, next_double_density_select, next_standby, next_foreign;
  logic take, pop;
  assign take = cmd_valid && cmd_ready;
  assign pop = res_valid && res_read;
  always_comb begin
    next_state = state;
    next_buf = res_buf;
    next_res_count = res_count;
    next_res_idx = res_idx;
    next_dsel = dsel;
    next_last_fmt = last_fmt;
    next_rs_dir = rs_dir;
    next_res_valid = res_valid;
    next_res_byte = res_byte;
    next_lock = config_lock;
    next_seek_start = 1'b0;
    next_seek_dir = seek_dir;
    next_seek_drive = seek_drive;
    next_seek_head = seek_head;
    next_seek_steps = seek_steps;
    next_read_id_start = 1'b0;
    next_read_id_drive = read_id_drive;
    next_read_id_head = read_id_head;
    next_double_density_select = double_density_select;
    next_standby = 1'b0;
    next_foreign = 1'b0;
    if (format_done) begin
      next_last_fmt = 1'b1; // see RULE3
    end else if (rw_done) begin
      next_last_fmt = 1'b0; // see RULE4
    end
    case (state)
      ST_IDLE: begin
        if (take) begin
          if ((cmd_byte & `RSEEK_MASK) == `RSEEK_CODE) begin
            next_rs_dir = cmd_byte[`DIR_BIT]; // see RULE1
            next_state = ST_SEEK_DRV;
          end else if ((cmd_byte & `LOCK_MASK) == `LOCK_CODE) begin
            next_lock = cmd_byte[`LOCK_BIT]; // see RULE9
            next_buf[0] = {3'h0, cmd_byte[`LOCK_BIT], 4'h0}; // see RULE10
            next_res_count = `LOCK_RES_LEN;
            next_state = ST_RESULT;
          end else if (cmd_byte == `DUMP_CODE) begin
            next_buf[0] = present_cylinder_0; // see RULE11
            next_buf[1] = present_cylinder_1;
            next_buf[2] = present_cylinder_2;
            next_buf[3] = present_cylinder_3;
            next_buf[4] = {step_rate_time, head_unload_time};
            next_buf[5] = {head_load_time, non_dma_flag};
            next_buf[6] = last_fmt ? sector_count : final_sector_number; // see RULE3 see RULE4
            next_buf[7] = {config_lock, 1'b0, dsel, gap_select, write_gate_select}; // see RULE2
            next_buf[8] = {1'b0, implied_seek_enable, fifo_disable, poll_disable, fifo_threshold};
            next_buf[9] = precomp_start_track;
            next_res_count = `DUMP_RES_LEN;
            next_state = ST_RESULT;
          end else if ((cmd_byte & `RID_MASK) == `RID_CODE) begin
            next_double_density_select = cmd_byte[`DENSITY_BIT];
            next_state = ST_RID_DRV;
          end else if (is_foreign(cmd_byte)) begin
            next_foreign = 1'b1;
          end else begin
            next_standby = 1'b1; // see RULE8
            next_buf[0] = `INVALID_STATUS;
            next_res_count = `INVALID_RES_LEN;
            next_state = ST_RESULT;
          end
          if (next_state == ST_RESULT) begin
            next_res_idx = 4'h0;
            next_res_valid = 1'b1;
            next_res_byte = next_buf[0];
          end
        end
      end
      ST_SEEK_DRV: begin
        if (take) begin
          next_seek_drive = cmd_byte[1:0];
          next_seek_head = cmd_byte[`HEAD_BIT];
          next_dsel = 4'h1 << cmd_byte[1:0]; // see RULE5
          next_state = ST_SEEK_CNT;
        end
      end
      ST_SEEK_CNT: begin
        if (take) begin
          next_seek_steps = cmd_byte; // see RULE1
          next_seek_dir = rs_dir;
          next_seek_start = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_RID_DRV: begin
        if (take) begin
          next_read_id_drive = cmd_byte[1:0];
          next_read_id_head = cmd_byte[`HEAD_BIT];
          next_dsel = 4'h1 << cmd_byte[1:0]; // see RULE5
          next_read_id_start = 1'b1;
          next_state = ST_RID_WAIT;
        end
      end
      ST_RID_WAIT: begin
        if (id_found) begin
          next_buf[0] = id_status_0; // see RULE7
          next_buf[1] = id_status_1;
          next_buf[2] = id_status_2;
          next_buf[3] = id_cylinder;
          next_buf[4] = id_head;
          next_buf[5] = id_sector;
          next_buf[6] = id_size;
          next_res_count = `RID_RES_LEN;
          next_res_idx = 4'h0;
          next_res_valid = 1'b1;
          next_res_byte = id_status_0;
          next_state = ST_RESULT;
        end
      end
      ST_RESULT: begin
        if (pop) begin
          if (res_idx == res_count - 4'h1) begin
            next_res_valid = 1'b0;
            next_state = ST_IDLE;
          end else begin
            next_res_idx = res_idx + 4'h1;
            next_res_byte = res_buf[res_idx + 4'h1];
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_cmd_ready = (next_state == ST_IDLE) || (next_state == ST_SEEK_DRV) ||
                     (next_state == ST_SEEK_CNT) || (next_state == ST_RID_DRV);
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      for (int i = 0; i < `RES_DEPTH; i++) begin
        res_buf[i] <= 8'h00;
      end
      res_count <= 4'h0;
      res_idx <= 4'h0;
      dsel <= `DSEL_RESET;
      last_fmt <= 1'b0;
      rs_dir <= 1'b0;
      res_valid <= 1'b0;
      res_byte <= 8'h00;
      cmd_ready <= 1'b1;
      config_lock <= `LOCK_RESET;
      seek_start <= 1'b0;
      seek_dir <= 1'b0;
      seek_drive <= 2'h0;
      seek_head <= 1'b0;
      seek_steps <= 8'h00;
      read_id_start <= 1'b0;
      read_id_drive <= 2'h0;
      read_id_head <= 1'b0;
      double_density_select <= 1'b0;
      standby_enter <= 1'b0;
      foreign_cmd <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      res_buf <= next_buf;
      res_count <= next_res_count;
      res_idx <= next_res_idx;
      dsel <= next_dsel;
      last_fmt <= next_last_fmt;
      rs_dir <= next_rs_dir;
      res_valid <= next_res_valid;
      res_byte <= next_res_byte;
      cmd_ready <= next_cmd_ready;
      config_lock <= next_lock;
      seek_start <= next_seek_start;
      seek_dir <= next_seek_dir;
      seek_drive <= next_seek_drive;
      seek_head <= next_seek_head;
      seek_steps <= next_seek_steps;
      read_id_start <= next_read_id_start;
      read_id_drive <= next_read_id_drive;
      read_id_head <= next_read_id_head;
      double_density_select <= next_double_density_select;
      standby_enter <= next_standby;
      foreign_cmd <= next_foreign;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_RSEEK_DIR: assert property (clk_en && state == ST_IDLE && take && (cmd_byte & `RSEEK_MASK) == `RSEEK_CODE
    |=> state == ST_SEEK_DRV && rs_dir == $past(cmd_byte[`DIR_BIT])) else $error("relative seek decode"); // see RULE1
  AST_RSEEK_ISSUE: assert property (clk_en && state == ST_SEEK_CNT && take
    |=> seek_start && seek_steps == $past(cmd_byte) && seek_dir == $past(rs_dir)) else $error("seek issue"); // see RULE1
  AST_DUMP_SELECT: assert property (clk_en && state == ST_IDLE && take && cmd_byte == `DUMP_CODE
    |=> res_buf[7] == {$past(config_lock), 1'b0, $past(dsel), $past(gap_select), $past(write_gate_select)})
    else $error("dump select byte"); // see RULE2
  AST_DUMP_COUNT_FIELD: assert property (clk_en && state == ST_IDLE && take && cmd_byte == `DUMP_CODE
    |=> res_buf[6] == ($past(last_fmt) ? $past(sector_count) : $past(final_sector_number)))
    else $error("dump count field"); // see RULE3
  AST_LAST_RW: assert property (clk_en && rw_done && !format_done |=> !last_fmt) else $error("rw tracking"); // see RULE4
  AST_RID_CAPTURE: assert property (clk_en && state == ST_RID_WAIT && id_found
    |=> res_valid && res_count == `RID_RES_LEN && res_buf[3] == $past(id_cylinder) && res_byte == $past(id_status_0))
    else $error("read id capture"); // see RULE7
  AST_INVALID: assert property (clk_en && state == ST_IDLE && take && (cmd_byte & `RSEEK_MASK) != `RSEEK_CODE &&
    (cmd_byte & `LOCK_MASK) != `LOCK_CODE && cmd_byte != `DUMP_CODE && (cmd_byte & `RID_MASK) != `RID_CODE &&
    !is_foreign(cmd_byte) |=> standby_enter && res_byte == `INVALID_STATUS && res_count == `INVALID_RES_LEN)
    else $error("invalid code answer"); // see RULE8
  AST_LOCK_STORE: assert property (clk_en && state == ST_IDLE && take && (cmd_byte & `LOCK_MASK) == `LOCK_CODE
    |=> config_lock == $past(cmd_byte[`LOCK_BIT])) else $error("lock store"); // see RULE9
  AST_LOCK_RESULT: assert property (clk_en && state == ST_IDLE && take && (cmd_byte & `LOCK_MASK) == `LOCK_CODE
    |=> res_byte == {3'h0, $past(cmd_byte[`LOCK_BIT]), 4'h0} && res_count == `LOCK_RES_LEN)
    else $error("lock result"); // see RULE10
  AST_DUMP_ORDER: assert property (clk_en && state == ST_IDLE && take && cmd_byte == `DUMP_CODE
    |=> res_count == `DUMP_RES_LEN && res_byte == $past(present_cylinder_0) && res_buf[9] == $past(precomp_start_track))
    else $error("dump order"); // see RULE11
endmodule : disk_ctrl_cmd_decode
